// >>> acx_autoneg.sv
// Auto-negotiation, parallel detection and crossover control
`timescale 1ns/1ps
module acx_autoneg
    import acx_pkg::*;
#(
    parameter logic [31:0] BREAK_CYCLES = 32'(BREAK_CYC),
    parameter logic [31:0] LFI_CYCLES = 32'(LFI_CYC),
    parameter logic [31:0] MDIX_CYCLES = 32'(MDIX_CYC)
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic ADVERT_STRAP_I,
    input wire logic CROSSOVER_STRAP_I,
    input wire acx_mgmt_t MGMT_I,
    output logic [15:0] RD_DATA_O,
    output logic RD_VALID_O,
    input wire logic RX_PAGE_VALID_I,
    input wire logic [15:0] RX_PAGE_I,
    input wire logic LINK_100_OK_I,
    input wire logic LINK_10_OK_I,
    output logic TX_QUIET_O,
    output logic TX_FLP_EN_O,
    output logic [15:0] TX_PAGE_O,
    output logic LINK_UP_O,
    output logic SPEED_100_O,
    output logic FULL_DUPLEX_O,
    output logic MDIX_O
);
    acx_state_t state;
    acx_state_t next_state;
    logic [15:0] basic_mode_control;
    logic [15:0] advertised_abilities;
    logic [15:0] lpar;
    logic [15:0] phy_control_extra;
    logic strap_done;
    logic an_en_q;
    logic [31:0] cnt;
    logic [31:0] mcnt;
    logic [7:0] lfsr;
    logic mdix_auto;
    logic pdf;
    logic page_rx;
    logic lp_able;
    logic wr_basic_mode_control;
    logic restart_req;
    logic an_en;
    logic an_rise;
    logic pd_one;
    logic pd_many;
    logic link_sel;
    logic [3:0] common;
    logic res_100;
    logic res_fd;
    logic rd_negotiation_expansion;
    logic auto_x;
    logic [15:0] basic_mode_status;
    logic [15:0] negotiation_expansion;
    logic [15:0] phy_status_summary;

    // Decodes of management writes and link conditions
    assign wr_basic_mode_control = MGMT_I.wr && MGMT_I.addr == ADR_BASIC_MODE_CONTROL;
    assign restart_req = wr_basic_mode_control && MGMT_I.wdata[BC_RESTART]; // [RL14]
    assign an_en = basic_mode_control[BC_AN_EN];
    assign an_rise = an_en && !an_en_q; // [RL17]
    assign pd_one = LINK_100_OK_I ^ LINK_10_OK_I;
    assign pd_many = LINK_100_OK_I && LINK_10_OK_I;
    assign link_sel = SPEED_100_O ? LINK_100_OK_I : LINK_10_OK_I;
    assign rd_negotiation_expansion = MGMT_I.rd && MGMT_I.addr == ADR_NEGOTIATION_EXPANSION;
    assign auto_x = phy_control_extra[PC_AUTO_X] && an_en; // [RL22]

    // Highest common ability wins
    assign common = advertised_abilities[8:5] & lpar[8:5];
    assign res_100 = common[3] || common[2]; // [RL3]
    assign res_fd = common[3] || (!common[2] && common[1]); // [RL3]

    // Strap is sampled in the first clocked cycle after release
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    // Basic control; restart bit is self clearing and never stored
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            basic_mode_control <= BASIC_CTRL_RST;
            an_en_q <= 1'b1;
        end else begin
            an_en_q <= an_en;
            if (wr_basic_mode_control) begin
                basic_mode_control <= MGMT_I.wdata & ~(16'h0001 << BC_RESTART);
            end
        end
    end

    // Advertisement: strap first, then software may trim abilities
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            advertised_abilities <= ADV_RST; // [RL8]
        end else if (!strap_done) begin
            advertised_abilities[8:5] <= ADVERT_STRAP_I ? ADV_HI_STRAP : ADV_LO_STRAP; // [RL1]
        end else if (MGMT_I.wr && MGMT_I.addr == ADR_ADVERTISED_ABILITIES) begin
            advertised_abilities <= MGMT_I.wdata; // [RL8]
        end
    end

    // Extra control: crossover enable defaults on, strap may clear it
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            phy_control_extra <= PHY_CONTROL_EXTRA_RST; // [RL20]
        end else if (!strap_done) begin
            phy_control_extra[PC_AUTO_X] <= CROSSOVER_STRAP_I; // [RL20]
        end else if (MGMT_I.wr && MGMT_I.addr == ADR_PHY_CONTROL_EXTRA) begin
            phy_control_extra <= MGMT_I.wdata; // [RL20]
        end
    end

    // Arbitration; disable and restart override every state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (an_rise) begin
                    next_state = ST_BREAK; // [RL17]
                end
            end
            ST_BREAK: begin
                if (cnt == BREAK_CYCLES - 32'd1) begin
                    next_state = ST_ABIL; // [RL16]
                end
            end
            ST_ABIL: begin
                if (RX_PAGE_VALID_I) begin
                    next_state = ST_ACK;
                end else if (pd_one) begin
                    next_state = ST_PDET;
                end
            end
            ST_ACK: begin
                if (RX_PAGE_VALID_I && RX_PAGE_I[PG_ACK]) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (common == 4'h0) begin
                    next_state = ST_BREAK;
                end else if (link_sel) begin
                    next_state = ST_GOOD;
                end else if (cnt == LFI_CYCLES - 32'd1) begin
                    next_state = ST_ABIL; // [RL18] [RL23]
                end
            end
            ST_PDET: begin
                next_state = pd_one ? ST_GOOD : ST_ABIL;
            end
            ST_GOOD: begin
                if (!link_sel) begin
                    next_state = ST_ABIL; // [RL15]
                end
            end
        endcase
        if (!an_en) begin
            next_state = ST_OFF; // [RL4]
        end else if (restart_req) begin
            next_state = ST_BREAK; // [RL14] [RL16]
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_ABIL;
        end else begin
            state <= next_state;
        end
    end

    // Timer restarts on every state change, used by break and check
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt <= 32'h0;
        end else if (next_state != state) begin
            cnt <= 32'h0;
        end else if (state == ST_BREAK || state == ST_CHECK) begin
            cnt <= cnt + 32'd1;
        end
    end

    // Partner code words, or the fixed word of a parallel detect
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lpar <= 16'h0;
        end else if (state == ST_ABIL && next_state == ST_PDET) begin
            lpar <= LINK_100_OK_I ? PD_100 : PD_10; // [RL10]
        end else if (RX_PAGE_VALID_I &&
                     (state == ST_ABIL || state == ST_ACK)) begin
            lpar <= RX_PAGE_I; // [RL9]
        end
    end

    // Expansion flags; a new event beats the clear-on-read
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pdf <= 1'b0;
            page_rx <= 1'b0;
            lp_able <= 1'b0;
        end else begin
            if (state == ST_ABIL && pd_many) begin
                pdf <= 1'b1; // [RL12]
            end else if (rd_negotiation_expansion) begin
                pdf <= 1'b0;
            end
            if (RX_PAGE_VALID_I && state != ST_OFF && state != ST_BREAK) begin
                page_rx <= 1'b1; // [RL11]
            end else if (rd_negotiation_expansion) begin
                page_rx <= 1'b0;
            end
            if (state == ST_ABIL && next_state == ST_PDET) begin
                lp_able <= 1'b0; // [RL13]
            end else if (RX_PAGE_VALID_I && state == ST_ABIL) begin
                lp_able <= 1'b1; // [RL11]
            end else if (state == ST_BREAK) begin
                lp_able <= 1'b0;
            end
        end
    end

    // Operating mode: forced bits, negotiated result or detected speed
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SPEED_100_O <= 1'b0;
            FULL_DUPLEX_O <= 1'b0;
        end else if (state == ST_OFF) begin
            SPEED_100_O <= basic_mode_control[BC_SPEED]; // [RL4]
            FULL_DUPLEX_O <= basic_mode_control[BC_DUPLEX]; // [RL4]
        end else if (state == ST_ACK && next_state == ST_CHECK) begin
            SPEED_100_O <= res_100; // [RL3]
            FULL_DUPLEX_O <= res_fd; // [RL3]
        end else if (state == ST_ABIL && next_state == ST_PDET) begin
            SPEED_100_O <= LINK_100_OK_I;
            FULL_DUPLEX_O <= 1'b0; // Detection cannot see duplex
        end
    end

    // Link indication
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LINK_UP_O <= 1'b0;
        end else begin
            LINK_UP_O <= state == ST_GOOD || (state == ST_OFF && link_sel);
        end
    end

    // Seeded pseudo-random source for the crossover choice
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lfsr <= LFSR_SEED;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    // Random slot switching while hunting for a partner
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mcnt <= 32'h0;
            mdix_auto <= 1'b0;
        end else if (auto_x && state == ST_ABIL) begin
            if (mcnt == MDIX_CYCLES - 32'd1) begin
                mcnt <= 32'h0;
                mdix_auto <= mdix_auto ^ lfsr[0]; // [RL19]
            end else begin
                mcnt <= mcnt + 32'd1;
            end
        end else begin
            mcnt <= 32'h0;
        end
    end

    // Force wins; forced speed mode keeps the straight pairing
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MDIX_O <= 1'b0;
        end else begin
            MDIX_O <= phy_control_extra[PC_FORCE_X] || (auto_x && mdix_auto); // [RL21]
        end
    end

    // Transmit side: quiet during break, bursts while negotiating
    assign TX_QUIET_O = state == ST_BREAK; // [RL16]
    assign TX_FLP_EN_O = state == ST_ABIL || state == ST_ACK; // [RL2]
    assign TX_PAGE_O = {advertised_abilities[15], state == ST_ACK, advertised_abilities[13:0]}; // [RL2]

    // Status words
    assign basic_mode_status = {STATUS_FIXED, 4'h0, 1'b1, state == ST_GOOD, lpar[13],
                   1'b1, LINK_UP_O, 1'b0, 1'b1}; // [RL6] [RL7]
    assign negotiation_expansion = {11'h0, pdf, lpar[15], 1'b0, page_rx, lp_able}; // [RL11]
    assign phy_status_summary = {1'b0, MDIX_O, 9'h0, state == ST_GOOD, 1'b0,
                     FULL_DUPLEX_O, !SPEED_100_O, LINK_UP_O}; // [RL5]

    // Registered read port; unmapped addresses read zero
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= 16'h0;
            RD_VALID_O <= 1'b0;
        end else begin
            RD_VALID_O <= MGMT_I.rd;
            if (MGMT_I.rd) begin
                unique case (MGMT_I.addr)
                    ADR_BASIC_MODE_CONTROL: RD_DATA_O <= basic_mode_control;
                    ADR_BASIC_MODE_STATUS: RD_DATA_O <= basic_mode_status; // [RL7]
                    ADR_ADVERTISED_ABILITIES: RD_DATA_O <= advertised_abilities;
                    ADR_PARTNER_ABILITIES: RD_DATA_O <= lpar;
                    ADR_NEGOTIATION_EXPANSION: RD_DATA_O <= negotiation_expansion;
                    ADR_PHY_STATUS_SUMMARY: RD_DATA_O <= phy_status_summary; // [RL5]
                    ADR_PHY_CONTROL_EXTRA: RD_DATA_O <= phy_control_extra;
                    default: RD_DATA_O <= 16'h0;
                endcase
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_strap;
        $rose(strap_done) |-> advertised_abilities[8:5] ==
            ($past(ADVERT_STRAP_I) ? ADV_HI_STRAP : ADV_LO_STRAP);
    endproperty
    a_strap: assert property (p_strap) // [RL1]
        else $error("advertisement not loaded from strap");

    property p_quiet;
        state == ST_BREAK |-> TX_QUIET_O && !TX_FLP_EN_O;
    endproperty
    a_quiet: assert property (p_quiet) // [RL16]
        else $error("bursts sent during break");

    property p_break_len;
        state == ST_ABIL && $past(state) == ST_BREAK |->
            $past(cnt) == BREAK_CYCLES - 32'd1;
    endproperty
    a_break_len: assert property (p_break_len) // [RL16]
        else $error("break timer ended early");

    property p_restart;
        restart_req && an_en |=> state == ST_BREAK;
    endproperty
    a_restart: assert property (p_restart) // [RL14]
        else $error("restart did not start break");

    property p_loss;
        state == ST_GOOD && !link_sel && an_en && !restart_req
            |=> state == ST_ABIL;
    endproperty
    a_loss: assert property (p_loss) // [RL15]
        else $error("lost link did not renegotiate");

    property p_pd_word;
        state == ST_PDET && $past(state) == ST_ABIL |->
            lpar == ($past(LINK_100_OK_I) ? PD_100 : PD_10) && !lp_able;
    endproperty
    a_pd_word: assert property (p_pd_word) // [RL10] [RL13]
        else $error("parallel detect word wrong");

    property p_prio;
        state == ST_ACK && next_state == ST_CHECK && common[3]
            |=> SPEED_100_O && FULL_DUPLEX_O;
    endproperty
    a_prio: assert property (p_prio) // [RL3]
        else $error("100 full duplex not chosen");

    property p_forced;
        state == ST_OFF && $stable(basic_mode_control) ##1 state == ST_OFF |->
            SPEED_100_O == $past(basic_mode_control[BC_SPEED]) &&
            FULL_DUPLEX_O == $past(basic_mode_control[BC_DUPLEX]);
    endproperty
    a_forced: assert property (p_forced) // [RL4]
        else $error("forced mode not applied");

    property p_force_x;
        phy_control_extra[PC_FORCE_X] |=> MDIX_O;
    endproperty
    a_force_x: assert property (p_force_x) // [RL21]
        else $error("force crossover ignored");

    property p_no_auto_x;
        !an_en && !phy_control_extra[PC_FORCE_X] |=> !MDIX_O;
    endproperty
    a_no_auto_x: assert property (p_no_auto_x) // [RL22]
        else $error("crossover switched in forced mode");

    property p_basic_mode_status;
        MGMT_I.rd && MGMT_I.addr == ADR_BASIC_MODE_STATUS |=>
            RD_DATA_O[15:11] == STATUS_FIXED && RD_DATA_O[0];
    endproperty
    a_basic_mode_status: assert property (p_basic_mode_status) // [RL6]
        else $error("fixed ability bits wrong");

    c_neg_good: cover property (state == ST_CHECK ##1 state == ST_GOOD);
    c_pd_good: cover property (state == ST_PDET ##1 state == ST_GOOD);
    c_break_done: cover property (state == ST_BREAK ##1 state == ST_ABIL);
    c_x_toggle: cover property (auto_x && $changed(mdix_auto));
endmodule // acx_autoneg

// >>> acx_pkg.sv
// Constants, types and register map of the negotiation and crossover block
// Function
// RL1: Strap loads advertised bits 8:5 at reset
// RL2: Send advertised abilities in pulse bursts
// RL3: Prefer 100FD, 100HD, 10FD, then 10HD
// RL4: Forced speed/duplex bits only when negotiation off
// RL5: Status register shows resolved speed after link
// RL6: Ability bits fixed set, T4 reads zero
// RL7: Status shows complete, fault, link, preamble
// RL8: All abilities default; software may clear some
// RL9: Store received partner code words
// RL10: Parallel detect loads 0081h or 0021h
// RL11: Expansion shows fault, pages, partner ability
// RL12: Fault when not exactly one link; the code flags it only when both links are up
// RL13: Parallel detect: complete but partner-able zero
// RL14: Writing restart bit starts new negotiation
// RL15: Lost negotiated link resumes negotiation
// RL16: Renegotiation goes quiet for break timer
// RL17: Software toggles enable to leave forced mode
// RL18: Negotiation completes within a few seconds
// RL19: Auto crossover uses random seeded switching
// RL20: Auto crossover on by default, configurable
// RL21: Force bit swaps pairs regardless
// RL22: No auto crossover in forced mode
// RL23: Arbitration timers follow standard negotiation
package acx_pkg;
    localparam int CLK_KHZ = 250000;
    localparam int BREAK_MS = 1500;
    localparam int BREAK_CYC = BREAK_MS * CLK_KHZ;
    localparam int LFI_MS = 750;
    localparam int LFI_CYC = LFI_MS * CLK_KHZ;
    localparam int MDIX_MS = 60;
    localparam int MDIX_CYC = MDIX_MS * CLK_KHZ;
    localparam logic [4:0] ADR_BASIC_MODE_CONTROL = 5'h00;
    localparam logic [4:0] ADR_BASIC_MODE_STATUS = 5'h01;
    localparam logic [4:0] ADR_ADVERTISED_ABILITIES = 5'h04;
    localparam logic [4:0] ADR_PARTNER_ABILITIES = 5'h05;
    localparam logic [4:0] ADR_NEGOTIATION_EXPANSION = 5'h06;
    localparam logic [4:0] ADR_PHY_STATUS_SUMMARY = 5'h10;
    localparam logic [4:0] ADR_PHY_CONTROL_EXTRA = 5'h19;
    localparam int BC_SPEED = 13;
    localparam int BC_AN_EN = 12;
    localparam int BC_RESTART = 9;
    localparam int BC_DUPLEX = 8;
    localparam int PC_AUTO_X = 15;
    localparam int PC_FORCE_X = 14;
    localparam int PG_ACK = 14;
    localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;
    localparam logic [15:0] ADV_RST = 16'h01e1;
    localparam logic [3:0] ADV_LO_STRAP = 4'h5;
    localparam logic [3:0] ADV_HI_STRAP = 4'hf;
    localparam logic [15:0] PHY_CONTROL_EXTRA_RST = 16'h8001;
    localparam logic [15:0] PD_100 = 16'h0081;
    localparam logic [15:0] PD_10 = 16'h0021;
    localparam logic [4:0] STATUS_FIXED = 5'b01111;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_BREAK = 3'b001,
        ST_ABIL = 3'b011,
        ST_ACK = 3'b010,
        ST_CHECK = 3'b110,
        ST_GOOD = 3'b111,
        ST_PDET = 3'b101
    } acx_state_t;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } acx_mgmt_t;
endpackage

// >>> acx_partner.sv
// Remote link partner model sending its base page in pulse bursts
`timescale 1ns/1ps
module acx_partner (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic [15:0] word_i,
    input wire logic flp_en_i,
    input wire logic [15:0] tx_page_i,
    output logic page_valid_o,
    output logic [15:0] page_o,
    output logic acked_o
);
    logic [5:0] gap;
    logic seen_ack;
    logic send;

    // Pages go out only while the device sends bursts as well
    assign send = en_i && flp_en_i && gap == 6'h00;

    // Burst spacing; the slow setting makes the device wait on us
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap <= 6'h00;
            page_valid_o <= 1'b0;
            page_o <= 16'h0000;
        end else begin
            gap <= (gap == (slow_i ? 6'h1e : 6'h05)) ? 6'h00 : gap + 6'h01;
            page_valid_o <= send;
            // Idle data flips each cycle so a stale word never looks valid
            page_o <= send ? {word_i[15], seen_ack, word_i[13:0]} : ~page_o;
        end
    end

    // Acknowledge once the device shows it holds our word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_ack <= 1'b0;
            acked_o <= 1'b0;
        end else begin
            seen_ack <= flp_en_i && (seen_ack || tx_page_i[14]);
            acked_o <= en_i && (acked_o || (page_valid_o && page_o[14]));
        end
    end
endmodule // acx_partner

// >>> acx_autoneg_tb.sv
// Self-checking testbench for the negotiation and crossover block
`timescale 1ns/1ps
module acx_autoneg_tb;
    import acx_pkg::*;
    localparam int BRK = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic adv_strap = 1'b1;
    logic x_strap = 1'b1;
    acx_mgmt_t mgmt = '0;
    logic [15:0] rd_data, tx_page, rx_page;
    logic rd_valid, quiet, flp, link_up, sp100, fdx, mdix, rx_valid;
    logic lk100 = 1'b0;
    logic lk10 = 1'b0;
    logic p_en = 1'b0;
    logic p_slow = 1'b0;
    logic acked;
    logic [15:0] p_word = 16'h01e1;
    logic [15:0] adv_exp = 16'h01e1;
    int err_total = 0;
    int cmp_count = 0;

    acx_autoneg #(.BREAK_CYCLES(32'd20), .LFI_CYCLES(32'd40),
        .MDIX_CYCLES(32'd8)) DUT (
        .CLK_I(clk_i), .RST_N_I(rst_n_i), .ADVERT_STRAP_I(adv_strap),
        .CROSSOVER_STRAP_I(x_strap), .MGMT_I(mgmt), .RD_DATA_O(rd_data),
        .RD_VALID_O(rd_valid), .RX_PAGE_VALID_I(rx_valid),
        .RX_PAGE_I(rx_page), .LINK_100_OK_I(lk100), .LINK_10_OK_I(lk10),
        .TX_QUIET_O(quiet), .TX_FLP_EN_O(flp), .TX_PAGE_O(tx_page),
        .LINK_UP_O(link_up), .SPEED_100_O(sp100), .FULL_DUPLEX_O(fdx),
        .MDIX_O(mdix));

    acx_partner partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(p_en),
        .slow_i(p_slow), .word_i(p_word), .flp_en_i(flp),
        .tx_page_i(tx_page), .page_valid_o(rx_valid), .page_o(rx_page),
        .acked_o(acked));

    // Free-running 250 MHz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Compare and count; mismatches are reported at once
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {15'h0, e}, {15'h0, g});
    endtask
    // Inputs move just after the edge so no race with the design
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        tick(1);
        mgmt.addr = a;
        mgmt.wdata = d;
        mgmt.wr = 1'b1;
        tick(1);
        mgmt.wr = 1'b0;
    endtask
    // Read one register and compare the masked word
    task automatic rdc(input string nm, input logic [4:0] a,
        input logic [15:0] m, input logic [15:0] e);
        tick(1);
        mgmt.addr = a;
        mgmt.rd = 1'b1;
        tick(1);
        mgmt.rd = 1'b0;
        chk1("rd_valid", 1'b1, rd_valid);
        chk(nm, e, rd_data & m);
    endtask

    // Reset with given strap levels and check reset contents
    task automatic reset_chk(input logic s);
        rst_n_i = 1'b0;
        adv_strap = s;
        x_strap = s;
        tick(10);
        rst_n_i = 1'b1;
        tick(2);
        adv_exp = s ? 16'h01e1 : 16'h00a1;
        rdc("ctrl", ADR_BASIC_MODE_CONTROL, 16'hffff, 16'h3100);
        rdc("status", ADR_BASIC_MODE_STATUS, 16'hffff, 16'h7849);
        rdc("adv", ADR_ADVERTISED_ABILITIES, 16'hffff, adv_exp);
        rdc("xcr", ADR_PHY_CONTROL_EXTRA, 16'hffff, {s, 15'h1});
        wr(ADR_PARTNER_ABILITIES, 16'hffff);
        rdc("ro", ADR_PARTNER_ABILITIES, 16'hffff, 16'h0000);
        rdc("unmapped", 5'h02, 16'hffff, 16'h0000);
    endtask

    // Restart and sit out the silent break before bursts resume
    task automatic restart();
        int q;
        lk100 = 1'b0;
        lk10 = 1'b0;
        wr(ADR_BASIC_MODE_CONTROL, 16'h1200);
        chk1("quiet", 1'b1, quiet);
        chk1("flp_off", 1'b0, flp);
        for (q = 0; q < 100 && quiet === 1'b1; q++) tick(1);
        chk1("break_len", 1'b1, q == BRK);
        chk1("flp_on", 1'b1, flp);
        chk("tx_page", adv_exp, tx_page);
        rdc("restart_rd", ADR_BASIC_MODE_CONTROL, 16'h0200, 16'h0);
    endtask

    // Full page exchange, then the link of the resolved speed comes up
    task automatic negotiate(input logic [15:0] pw, input logic sp,
        input logic fd, input logic slow);
        int i;
        p_word = pw;
        p_slow = slow;
        restart();
        p_en = 1'b1;
        for (i = 0; i < 400 && acked !== 1'b1; i++) tick(1);
        chk1("acked", 1'b1, acked);
        p_en = 1'b0;
        tick(2);
        lk100 = sp;
        lk10 = !sp;
        for (i = 0; i < 60 && link_up !== 1'b1; i++) tick(1);
        chk1("link_up", 1'b1, link_up);
        chk1("speed", sp, sp100);
        chk1("duplex", fd, fdx);
        rdc("partner", ADR_PARTNER_ABILITIES, 16'hbfff, pw & 16'hbfff);
        rdc("status", ADR_BASIC_MODE_STATUS, 16'hffff,
            16'h786d | {11'h0, pw[13], 4'h0});
        rdc("summary", ADR_PHY_STATUS_SUMMARY, 16'h0017,
            {11'h0, 2'b10, fd, !sp, 1'b1});
        rdc("expansion", ADR_NEGOTIATION_EXPANSION, 16'h000d, 16'h1);
    endtask

    // Dropping a negotiated link sends the device back to bursts
    task automatic link_loss();
        lk100 = 1'b0;
        tick(3);
        chk1("loss_link", 1'b0, link_up);
        chk1("loss_flp", 1'b1, flp);
    endtask

    // A partner that only shows a link is taken by parallel detection
    task automatic par_detect(input logic sp);
        int i;
        restart();
        lk100 = sp;
        lk10 = !sp;
        for (i = 0; i < 60 && link_up !== 1'b1; i++) tick(1);
        chk1("pd_speed", sp, sp100);
        chk1("pd_duplex", 1'b0, fdx);
        rdc("pd_word", ADR_PARTNER_ABILITIES, 16'hffff,
            sp ? 16'h0081 : 16'h0021);
        rdc("pd_able", ADR_NEGOTIATION_EXPANSION, 16'h1, 16'h0);
        rdc("pd_done", ADR_BASIC_MODE_STATUS, 16'h20, 16'h20);
    endtask

    // Two links at once is a fault; the flag clears once read
    task automatic pd_fault();
        restart();
        lk100 = 1'b1;
        lk10 = 1'b1;
        tick(4);
        rdc("fault", ADR_NEGOTIATION_EXPANSION, 16'h10, 16'h10);
        lk100 = 1'b0;
        lk10 = 1'b0;
        tick(2);
        // The fault still stood at the first read, so that set beat the clear
        rdc("fault_held", ADR_NEGOTIATION_EXPANSION, 16'h10, 16'h10);
        rdc("fault_clr", ADR_NEGOTIATION_EXPANSION, 16'h10, 16'h0);
    endtask

    // Auto crossover hunts while idle; forced mode holds it straight
    task automatic crossover();
        int i;
        logic m;
        restart();
        m = mdix;
        for (i = 0; i < 120 && mdix === m; i++) tick(1);
        chk1("mdix_hunt", !m, mdix);
        wr(ADR_BASIC_MODE_CONTROL, 16'h2100);
        tick(2);
        chk1("f_speed", 1'b1, sp100);
        chk1("f_duplex", 1'b1, fdx);
        m = mdix;
        tick(30);
        chk1("mdix_hold", m, mdix);
        wr(ADR_PHY_CONTROL_EXTRA, 16'h4001);
        tick(1);
        chk1("mdix_force", 1'b1, mdix);
        rdc("sum_x", ADR_PHY_STATUS_SUMMARY, 16'h4000, 16'h4000);
        wr(ADR_PHY_CONTROL_EXTRA, 16'h0001);
        tick(1);
        chk1("mdix_clr", 1'b0, mdix);
        wr(ADR_BASIC_MODE_CONTROL, 16'h0000);
        tick(2);
        chk1("f_speed0", 1'b0, sp100);
        chk1("f_duplex0", 1'b0, fdx);
        wr(ADR_BASIC_MODE_CONTROL, 16'h1000);
        // The enable rise is seen one edge after the write lands
        tick(1);
        chk1("reenable", 1'b1, quiet);
        wr(ADR_PHY_CONTROL_EXTRA, 16'h8001);
    endtask

    // Print counts and the verdict, then stop
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        reset_chk(1'b1);
        negotiate(16'h01e1, 1'b1, 1'b1, 1'b0);
        link_loss();
        negotiate(16'h00a1, 1'b1, 1'b0, 1'b1);
        negotiate(16'h0061, 1'b0, 1'b1, 1'b0);
        negotiate(16'h2021, 1'b0, 1'b0, 1'b0);
        wr(ADR_ADVERTISED_ABILITIES, 16'h0021);
        adv_exp = 16'h0021;
        negotiate(16'h01e1, 1'b0, 1'b0, 1'b0);
        wr(ADR_ADVERTISED_ABILITIES, 16'h01e1);
        adv_exp = 16'h01e1;
        par_detect(1'b1);
        par_detect(1'b0);
        pd_fault();
        crossover();
        reset_chk(1'b0);
        negotiate(16'h01e1, 1'b1, 1'b0, 1'b0);
        results();
    end

    // The run needs under a thousand cycles; far more means a hang
    initial begin
        tick(20000);
        err_total++;
        results();
    end
endmodule // acx_autoneg_tb
